// ---- logic/ccs_clock_switch.v ----
// CPU clock switch sequencer with processor_clock_ctrl over AXI4-Lite.
// Assumes i_clk is the main system clock, the CPU pulses i_instr_done once per
// instruction, and the subsystem oscillator stable flag arrives asynchronously.
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ccs_defines.vh"

module ccs_clock_switch #(
  parameter STAB_CYCLES = `CCS_STAB_PERIODS
) (
  // Clock and reset
  input  wire                    i_clk,
  input  wire                    i_rstn,
  // AXI4-Lite write address
  input  wire                    s_axi_awvalid,
  output wire                    s_axi_awready,
  input  wire [`CCS_ADDR_W-1:0]  s_axi_awaddr,
  input  wire [2:0]              s_axi_awprot,
  // AXI4-Lite write data
  input  wire                    s_axi_wvalid,
  output wire                    s_axi_wready,
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  // AXI4-Lite write response
  output wire                    s_axi_bvalid,
  input  wire                    s_axi_bready,
  output wire [1:0]              s_axi_bresp,
  // AXI4-Lite read address
  input  wire                    s_axi_arvalid,
  output wire                    s_axi_arready,
  input  wire [`CCS_ADDR_W-1:0]  s_axi_araddr,
  input  wire [2:0]              s_axi_arprot,
  // AXI4-Lite read data
  output wire                    s_axi_rvalid,
  input  wire                    s_axi_rready,
  output wire [31:0]             s_axi_rdata,
  output wire [1:0]              s_axi_rresp,
  // CPU and oscillators
  input  wire                    i_instr_done,
  input  wire                    i_sub_osc_stable,
  output wire                    o_cpu_hold,
  output wire                    o_main_osc_en,
  output wire                    o_cpu_src_sub,
  output wire [2:0]              o_cpu_div
);

  // Instructions the old clock keeps running for, per the old setting.
  function [`CCS_DLY_W-1:0] ccs_delay;
    input       old_sub;
    input [2:0] old_div;
    begin
      if (old_sub || old_div[2]) begin
        ccs_delay = `CCS_DLY_MIN;
      end else begin
        ccs_delay = `CCS_DLY_MAX >> old_div[1:0];
      end
    end
  endfunction

  // Bus state.
  reg                    aw_held_ff;
  reg [`CCS_ADDR_W-1:0]  aw_addr_ff;
  reg                    w_held_ff;
  reg [31:0]             w_data_ff;
  reg [3:0]              w_strb_ff;
  reg                    bvalid_ff;
  reg [1:0]              bresp_ff;
  reg                    rvalid_ff;
  reg [31:0]             rdata_ff;
  reg [1:0]              rresp_ff;

  // Control state.
  reg [2:0]              req_div_ff;
  reg                    req_sub_ff;
  reg                    stop_ff;
  reg [2:0]              cur_div_ff;
  reg                    cur_sub_ff;
  reg                    osc_en_ff;
  reg [`CCS_STAB_W-1:0]  stab_cnt_ff;
  reg                    stab_done_ff;
  reg                    sub_meta_ff;
  reg                    sub_sync_ff;

  wire                   wr_fire;
  wire                   wr_ctrl;
  wire                   sw_busy;
  wire                   sw_done;
  wire                   sw_load;
  wire [2:0]             wr_div;
  wire                   wr_sub;
  wire [7:0]             ctrl_rd;
  wire [7:0]             stat_rd;

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_ctrl = wr_fire && (aw_addr_ff == `CCS_REG_CTRL) && w_strb_ff[0];
  assign wr_div  = w_data_ff[`CCS_DIV_MSB:`CCS_DIV_LSB];
  assign wr_sub  = w_data_ff[`CCS_SRC_BIT];
  assign sw_load = wr_ctrl && ((wr_div != cur_div_ff) || (wr_sub != cur_sub_ff));

  assign ctrl_rd = {stop_ff, 1'b0, cur_sub_ff, req_sub_ff, 1'b0, req_div_ff};
  assign stat_rd = {4'h0, osc_en_ff, sub_sync_ff, sw_busy, !stab_done_ff};

  // Write address and data are taken independently, then paired.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= {`CCS_ADDR_W{1'b0}};
      w_held_ff  <= 1'b0;
      w_data_ff  <= 32'h00000000;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `CCS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        if ((aw_addr_ff == `CCS_REG_CTRL) || (aw_addr_ff == `CCS_REG_STAT)) begin
          bresp_ff <= `CCS_RESP_OKAY;
        end else begin
          bresp_ff <= `CCS_RESP_SLVERR;
        end
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Reads answer one cycle after the address is taken.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= `CCS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= `CCS_RESP_OKAY;
      if (s_axi_araddr == `CCS_REG_CTRL) begin
        rdata_ff <= {24'h000000, ctrl_rd};
      end else if (s_axi_araddr == `CCS_REG_STAT) begin
        rdata_ff <= {24'h000000, stat_rd};
      end else begin
        rdata_ff <= 32'h00000000;
        rresp_ff <= `CCS_RESP_SLVERR;
      end
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Subsystem stable flag crosses into i_clk through two flops.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sub_meta_ff <= 1'b0;
      sub_sync_ff <= 1'b0;
    end else begin
      sub_meta_ff <= i_sub_osc_stable;
      sub_sync_ff <= sub_meta_ff;
    end
  end

  // Requested settings; leave the write as given.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      req_div_ff <= `CCS_DIV_SLOWEST;
      req_sub_ff <= 1'b0;
      stop_ff    <= 1'b0;
    end else if (wr_ctrl) begin
      req_div_ff <= wr_div;
      req_sub_ff <= wr_sub;
      stop_ff    <= w_data_ff[`CCS_STOP_BIT];
    end
  end

  ccs_instr_counter u_instr_counter (
    .i_clk      (i_clk),
    .i_rstn     (i_rstn),
    .i_load     (sw_load),
    .i_load_val (ccs_delay(cur_sub_ff, cur_div_ff)),
    .i_tick     (i_instr_done && stab_done_ff),
    .o_busy     (sw_busy),
    .o_done     (sw_done)
  );

  // Active settings move only when the count ends.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cur_div_ff <= `CCS_DIV_SLOWEST;
      cur_sub_ff <= 1'b0;
    end else if (sw_done) begin
      cur_div_ff <= req_div_ff;
      cur_sub_ff <= req_sub_ff;
    end
  end

  // Main oscillator: off in reset, stops only once running from subsystem.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      osc_en_ff <= 1'b0;
    end else begin
      osc_en_ff <= !(stop_ff && cur_sub_ff);
    end
  end

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stab_cnt_ff  <= {`CCS_STAB_W{1'b0}};
      stab_done_ff <= 1'b0;
    end else if (!stab_done_ff && osc_en_ff) begin
      if (stab_cnt_ff == STAB_CYCLES[`CCS_STAB_W-1:0] - 1'b1) begin
        stab_done_ff <= 1'b1;
      end
      stab_cnt_ff <= stab_cnt_ff + 1'b1;
    end
  end

  // Clearing the stop bit does not re-hold the CPU; software times that wait.
  assign o_cpu_hold    = !stab_done_ff;
  assign o_main_osc_en = osc_en_ff;
  assign o_cpu_src_sub = cur_sub_ff;
  assign o_cpu_div     = cur_div_ff;

endmodule // ccs_clock_switch

// ---- logic/ccs_defines.vh ----
// Constants for the CPU clock switch sequencer: register map, field layout, reset
// values and timing counts.
// Assumes inclusion by bare name from the design files of this block.
`ifndef CCS_DEFINES_VH
`define CCS_DEFINES_VH

// Register byte addresses on the AXI4-Lite bus.
`define CCS_ADDR_W        4
`define CCS_REG_CTRL      4'h0
`define CCS_REG_STAT      4'h4

// Fields of processor_clock_ctrl.
`define CCS_DIV_MSB       2
`define CCS_DIV_LSB       0
`define CCS_SRC_BIT       4
`define CCS_IND_BIT       5
`define CCS_STOP_BIT      7
`define CCS_CTRL_RESET    8'h04
`define CCS_DIV_SLOWEST   3'h4

// Fields of the status register.
`define CCS_STAT_STAB_BIT 0
`define CCS_STAT_PEND_BIT 1
`define CCS_STAT_SUB_BIT  2
`define CCS_STAT_OSC_BIT  3

// Switchover delay in instructions.
`define CCS_DLY_W         5
`define CCS_DLY_MAX       5'h10
`define CCS_DLY_MIN       5'h01

// Oscillation stabilization wait in main clock periods.
`define CCS_STAB_PERIODS  131072
`define CCS_STAB_W        18

// AXI responses.
`define CCS_RESP_OKAY     2'h0
`define CCS_RESP_SLVERR   2'h2

`endif

// ---- logic/ccs_instr_counter.v ----
// Instruction down-counter for the delayed clock switchover.
// Assumes i_tick is a one-cycle pulse per retired instruction on i_clk.
`timescale 1ns/1ps
`include "ccs_defines.vh"

module ccs_instr_counter (
  // Clock and reset
  input  wire                    i_clk,
  input  wire                    i_rstn,
  // Control
  input  wire                    i_load,
  input  wire [`CCS_DLY_W-1:0]   i_load_val,
  input  wire                    i_tick,
  // Status
  output wire                    o_busy,
  output wire                    o_done
);

  reg [`CCS_DLY_W-1:0] cnt_ff;
  reg [`CCS_DLY_W-1:0] nxt_cnt;

  assign o_busy = (cnt_ff != {`CCS_DLY_W{1'b0}});
  // Last instruction on the old clock finishes the count.
  assign o_done = o_busy && i_tick && (cnt_ff == `CCS_DLY_MIN) && !i_load;

  always @* begin
    nxt_cnt = cnt_ff;
    if (i_load) begin
      nxt_cnt = i_load_val;
    end else if (o_busy && i_tick) begin
      nxt_cnt = cnt_ff - `CCS_DLY_MIN;
    end
  end

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_ff <= {`CCS_DLY_W{1'b0}};
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule // ccs_instr_counter

// ---- sim/ccs_clock_switch_asserts.sv ----
// Port checker for the CPU clock switch sequencer.
// Assumes it is bound to ccs_clock_switch and sees only its ports.
`timescale 1ns/1ps
`include "ccs_defines.vh"

module ccs_clock_switch_asserts #(
  parameter STAB_CYCLES = `CCS_STAB_PERIODS
) (
  // Clock and reset
  input wire       i_clk,
  input wire       i_rstn,
  // Bus handshakes
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  input wire       s_axi_rready,
  input wire       s_axi_bvalid,
  input wire       s_axi_bready,
  // CPU and oscillators
  input wire       i_instr_done,
  input wire       o_cpu_hold,
  input wire       o_main_osc_en,
  input wire       o_cpu_src_sub,
  input wire [2:0] o_cpu_div
);
  // Counts edges since reset release, saturating so it never wraps.
  int cyc_ff;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) cyc_ff <= 0;
    else if (cyc_ff < 100000) cyc_ff <= cyc_ff + 1;
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_hold_len: assert property ($fell(o_cpu_hold) |-> cyc_ff == STAB_CYCLES + 1)
    else $error("stabilization hold has wrong length");
  a_osc_start: assert property (cyc_ff == 1 |-> o_main_osc_en)
    else $error("main oscillator not started after reset");
  a_slow_start: assert property ($fell(o_cpu_hold) |->
    o_cpu_div == `CCS_DIV_SLOWEST && !o_cpu_src_sub)
    else $error("execution does not start at slowest main setting");
  a_div_on_instr: assert property ($changed(o_cpu_div) |->
    $past(i_instr_done) && !$past(o_cpu_hold))
    else $error("divider changed without an instruction");
  a_src_on_instr: assert property ($changed(o_cpu_src_sub) |->
    $past(i_instr_done) && !$past(o_cpu_hold))
    else $error("source changed without an instruction");
  a_stop_after_sub: assert property ($fell(o_main_osc_en) |-> $past(o_cpu_src_sub))
    else $error("main oscillator stopped while main clock in use");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_one_read: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated after it was taken");
  a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
endmodule // ccs_clock_switch_asserts

bind ccs_clock_switch ccs_clock_switch_asserts #(
  .STAB_CYCLES   (STAB_CYCLES)
) u_chk (
  .i_clk         (i_clk),
  .i_rstn        (i_rstn),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .i_instr_done  (i_instr_done),
  .o_cpu_hold    (o_cpu_hold),
  .o_main_osc_en (o_main_osc_en),
  .o_cpu_src_sub (o_cpu_src_sub),
  .o_cpu_div     (o_cpu_div)
);

// ---- sim/tb_top.sv ----
// Self-checking bench for the CPU clock switch sequencer.
// Assumes the checker file is compiled with it; bus answers are always accepted.
`timescale 1ns/1ps
`include "ccs_defines.vh"

module tb_top;
  localparam int STAB = 16;
  logic        i_clk = 1'b0, i_rstn = 1'b0, i_instr_done = 1'b0, i_sub_osc_stable = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         o_cpu_hold, o_main_osc_en, o_cpu_src_sub;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [2:0]   o_cpu_div;
  wire [31:0]  s_axi_rdata;
  int          bad_count = 0, total_checks = 0, cyc = 0;

  ccs_clock_switch #(
    .STAB_CYCLES      (STAB)
  ) dut (
    .i_clk            (i_clk),
    .i_rstn           (i_rstn),
    .s_axi_awvalid    (s_axi_awvalid),
    .s_axi_awready    (s_axi_awready),
    .s_axi_awaddr     (s_axi_awaddr),
    .s_axi_awprot     (s_axi_awprot),
    .s_axi_wvalid     (s_axi_wvalid),
    .s_axi_wready     (s_axi_wready),
    .s_axi_wdata      (s_axi_wdata),
    .s_axi_wstrb      (s_axi_wstrb),
    .s_axi_bvalid     (s_axi_bvalid),
    .s_axi_bready     (s_axi_bready),
    .s_axi_bresp      (s_axi_bresp),
    .s_axi_arvalid    (s_axi_arvalid),
    .s_axi_arready    (s_axi_arready),
    .s_axi_araddr     (s_axi_araddr),
    .s_axi_arprot     (s_axi_arprot),
    .s_axi_rvalid     (s_axi_rvalid),
    .s_axi_rready     (s_axi_rready),
    .s_axi_rdata      (s_axi_rdata),
    .s_axi_rresp      (s_axi_rresp),
    .i_instr_done     (i_instr_done),
    .i_sub_osc_stable (i_sub_osc_stable),
    .o_cpu_hold       (o_cpu_hold),
    .o_main_osc_en    (o_main_osc_en),
    .o_cpu_src_sub    (o_cpu_src_sub),
    .o_cpu_div        (o_cpu_div)
  );

  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= i_rstn ? cyc + 1 : 0;

  task automatic results;
    if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic die;
    chk(1'b0, "wait ran out");
    results();
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge i_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    if (!s_axi_bvalid) die();
    chk(s_axi_bresp === er, "write response");
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge i_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    if (!s_axi_rvalid) die();
    chk(s_axi_rdata === ed && s_axi_rresp === er, "read data or response");
  endtask

  task automatic instr(input int k);
    repeat (k) begin
      i_instr_done <= 1'b1;
      @(posedge i_clk);
      i_instr_done <= 1'b0;
      @(posedge i_clk);
    end
  endtask

  // Writes the control byte, then checks the switch lands on exactly the k-th instruction.
  task automatic sw(input logic [7:0] v, input int k);
    logic [3:0] old;
    old = {o_cpu_src_sub, o_cpu_div};
    axi_wr(`CCS_REG_CTRL, {24'h0, v}, `CCS_RESP_OKAY);
    instr(k - 1);
    chk({o_cpu_src_sub, o_cpu_div} === old, "switch came early");
    instr(1);
    chk({o_cpu_src_sub, o_cpu_div} === {v[4], v[2:0]}, "switch late or wrong");
  endtask

  initial begin
    int n;
    repeat (12) @(posedge i_clk);
    i_rstn <= 1'b1;
    axi_rd(`CCS_REG_CTRL, 32'h04, `CCS_RESP_OKAY);
    axi_rd(`CCS_REG_STAT, 32'h09, `CCS_RESP_OKAY);
    for (n = 0; n < 100 && o_cpu_hold; n++) @(posedge i_clk);
    chk(o_cpu_hold === 1'b0 && cyc == STAB + 1, "hold length");
    chk(o_cpu_div === `CCS_DIV_SLOWEST && o_cpu_src_sub === 1'b0, "slow start");
    if (o_cpu_hold !== 1'b0) die();
    sw(8'h00, 1);
    for (n = 0; n < 4; n++) sw(8'((n + 1) % 4), 16 >> n);
    i_sub_osc_stable <= 1'b1;
    axi_wr(`CCS_REG_CTRL, 32'h90, `CCS_RESP_OKAY);
    instr(15);
    chk(o_main_osc_en === 1'b1 && o_cpu_src_sub === 1'b0, "stopped early");
    axi_rd(`CCS_REG_CTRL, 32'h90, `CCS_RESP_OKAY);
    axi_rd(`CCS_REG_STAT, 32'h0E, `CCS_RESP_OKAY);
    instr(1);
    axi_rd(`CCS_REG_CTRL, 32'hB0, `CCS_RESP_OKAY);
    chk(o_main_osc_en === 1'b0, "main oscillator still on");
    axi_wr(`CCS_REG_CTRL, 32'h10, `CCS_RESP_OKAY);
    @(posedge i_clk);
    chk(o_main_osc_en === 1'b1 && o_cpu_src_sub === 1'b1, "restart");
    repeat (STAB) @(posedge i_clk);
    sw(8'h02, 1);
    axi_wr(4'h8, 32'hFF, `CCS_RESP_SLVERR);
    axi_rd(4'h8, 32'h0, `CCS_RESP_SLVERR);
    axi_wr(`CCS_REG_STAT, 32'hFF, `CCS_RESP_OKAY);
    s_axi_wstrb <= 4'h0;
    axi_wr(`CCS_REG_CTRL, 32'hFF, `CCS_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axi_rd(`CCS_REG_CTRL, 32'h02, `CCS_RESP_OKAY);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk(o_cpu_div === 3'h4 && !o_main_osc_en && o_cpu_hold, "mid-run reset");
    i_rstn <= 1'b1;
    axi_rd(`CCS_REG_CTRL, 32'h04, `CCS_RESP_OKAY);
    results();
  end
endmodule // tb_top
